// File: common/orc_pkg.sv
// package: register map, selector codes and divider constants for output rate select
`default_nettype none
package orc_pkg;
    // register offsets and reset values
    localparam logic [7:0] ORC_PAIR_A_OFFS = 8'h60;
    localparam logic [7:0] ORC_PAIR_B_OFFS = 8'h61;
    localparam logic [7:0] ORC_PAIR_A_RST = 8'h85;
    localparam logic [7:0] ORC_PAIR_B_RST = 8'h86;
    // field positions inside a pair register
    localparam int ORC_HI_LSB = 4;
    localparam int ORC_LO_LSB = 0;

    // core clock and fixed output rates
    localparam longint ORC_CORE_CLK_HZ = 250000000;
    localparam longint ORC_RATE_2K_HZ = 2000;
    localparam longint ORC_RATE_8K_HZ = 8000;
    localparam int ORC_HALF_2K_CYC = int'(ORC_CORE_CLK_HZ / (2 * ORC_RATE_2K_HZ));
    localparam int ORC_HALF_8K_CYC = int'(ORC_CORE_CLK_HZ / (2 * ORC_RATE_8K_HZ));

    // secondary pll rate field value for 62.5MHz
    localparam logic [3:0] ORC_SEC_RATE_62M5 = 4'h9;

    // selector codes
    localparam logic [3:0] ORC_SEL_OFF = 4'h0;
    localparam logic [3:0] ORC_SEL_2K = 4'h1;
    localparam logic [3:0] ORC_SEL_8K = 4'h2;
    localparam logic [3:0] ORC_SEL_PROG_TWO = 4'h3;
    localparam logic [3:0] ORC_SEL_PROG_ONE = 4'h4;
    localparam logic [3:0] ORC_SEL_MAIN_48 = 4'h5;
    localparam logic [3:0] ORC_SEL_MAIN_16 = 4'h6;
    localparam logic [3:0] ORC_SEL_MAIN_12 = 4'h7;
    localparam logic [3:0] ORC_SEL_MAIN_8 = 4'h8;
    localparam logic [3:0] ORC_SEL_MAIN_6 = 4'h9;
    localparam logic [3:0] ORC_SEL_MAIN_4 = 4'hA;
    localparam logic [3:0] ORC_SEL_SEC_64 = 4'hB;
    localparam logic [3:0] ORC_SEL_SEC_48 = 4'hC;
    localparam logic [3:0] ORC_SEL_SEC_16 = 4'hD;
    localparam logic [3:0] ORC_SEL_SEC_8 = 4'hE;
    localparam logic [3:0] ORC_SEL_SEC_4 = 4'hF;

    // half-period counts, in pll rising edges, for each divisor
    localparam logic [5:0] ORC_HALF_DIV48 = 6'd24;
    localparam logic [5:0] ORC_HALF_DIV16 = 6'd8;
    localparam logic [5:0] ORC_HALF_DIV12 = 6'd6;
    localparam logic [5:0] ORC_HALF_DIV8 = 6'd4;
    localparam logic [5:0] ORC_HALF_DIV6 = 6'd3;
    localparam logic [5:0] ORC_HALF_DIV4 = 6'd2;
    localparam logic [5:0] ORC_HALF_DIV64 = 6'd32;
    localparam logic [5:0] ORC_HALF_DIV10 = 6'd5;

    // output source kinds
    typedef enum logic [2:0] {
        ORC_SRC_OFF,
        ORC_SRC_2K,
        ORC_SRC_8K,
        ORC_SRC_PROG_TWO,
        ORC_SRC_PROG_ONE,
        ORC_SRC_MAIN,
        ORC_SRC_SEC
    } orc_src_t;

    // one configuration register: two selectors
    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
    } orc_pair_t;

    // decoded selector: source and half-period in pll edges
    typedef struct packed {
        orc_src_t src;
        logic [5:0] half;
    } orc_route_t;
endpackage : orc_pkg
`default_nettype wire

// File: hw/orc_output_clock_rate_select.sv
// output clock rate selection for the first four general output clocks
// Notes on behaviour
// - second output rate from bits 7:4 at 60h
// - first output rate from bits 3:0 at 60h
// - 61h: fourth output bits 7:4, third 3:0
// - code 0000 holds output low
// - 0001 gives 2kHz, 0010 gives 8kHz
// - 0011 second programmable rate, 0100 first
// - 0101..1010 main pll by 48,16,12,8,6,4
// - 1011,1101..1111 secondary pll by 64,16,8,4
// - 1100 normally secondary pll by 48
// - 1100 divides by 10 when 62.5MHz, lock 0
// - rates and pll setup come from elsewhere
`default_nettype none
module orc_output_clock_rate_select
    import orc_pkg::*;
#(
    parameter int half_2k_cyc = ORC_HALF_2K_CYC,
    parameter int half_8k_cyc = ORC_HALF_8K_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic main_analog_pll,
    input wire logic secondary_analog_pll,
    input wire logic programmable_rate_one,
    input wire logic programmable_rate_two,
    input wire logic [3:0] secondary_pll_rate_field,
    input wire logic secondary_apll_lock_source,
    output logic clock_output_one,
    output logic clock_output_two,
    output logic clock_output_three,
    output logic clock_output_four
);

    // selector decode, shared by all four outputs
    function automatic orc_route_t orc_decode(input logic [3:0] sel, input logic sec_25m);
        orc_route_t r;
        r.src = ORC_SRC_OFF;
        r.half = ORC_HALF_DIV4;
        case (sel)
            ORC_SEL_OFF: r.src = ORC_SRC_OFF;
            ORC_SEL_2K: r.src = ORC_SRC_2K;
            ORC_SEL_8K: r.src = ORC_SRC_8K;
            ORC_SEL_PROG_TWO: r.src = ORC_SRC_PROG_TWO;
            ORC_SEL_PROG_ONE: r.src = ORC_SRC_PROG_ONE;
            ORC_SEL_MAIN_48: begin
                r.src = ORC_SRC_MAIN;
                r.half = ORC_HALF_DIV48;
            end
            ORC_SEL_MAIN_16: begin
                r.src = ORC_SRC_MAIN;
                r.half = ORC_HALF_DIV16;
            end
            ORC_SEL_MAIN_12: begin
                r.src = ORC_SRC_MAIN;
                r.half = ORC_HALF_DIV12;
            end
            ORC_SEL_MAIN_8: begin
                r.src = ORC_SRC_MAIN;
                r.half = ORC_HALF_DIV8;
            end
            ORC_SEL_MAIN_6: begin
                r.src = ORC_SRC_MAIN;
                r.half = ORC_HALF_DIV6;
            end
            ORC_SEL_MAIN_4: begin
                r.src = ORC_SRC_MAIN;
                r.half = ORC_HALF_DIV4;
            end
            ORC_SEL_SEC_64: begin
                r.src = ORC_SRC_SEC;
                r.half = ORC_HALF_DIV64;
            end
            ORC_SEL_SEC_48: begin
                r.src = ORC_SRC_SEC;
                r.half = sec_25m ? ORC_HALF_DIV10 : ORC_HALF_DIV48;
            end
            ORC_SEL_SEC_16: begin
                r.src = ORC_SRC_SEC;
                r.half = ORC_HALF_DIV16;
            end
            ORC_SEL_SEC_8: begin
                r.src = ORC_SRC_SEC;
                r.half = ORC_HALF_DIV8;
            end
            ORC_SEL_SEC_4: begin
                r.src = ORC_SRC_SEC;
                r.half = ORC_HALF_DIV4;
            end
            default: r.src = ORC_SRC_OFF;
        endcase
        return r;
    endfunction

    // register file
    orc_pair_t pair_a_q;
    orc_pair_t pair_b_q;
    logic [7:0] rdata_q;
    wire logic wr_a = cpu_wr && (cpu_addr == ORC_PAIR_A_OFFS);
    wire logic wr_b = cpu_wr && (cpu_addr == ORC_PAIR_B_OFFS);
    wire logic [7:0] rd_mux = (cpu_addr == ORC_PAIR_A_OFFS) ? pair_a_q :
                              (cpu_addr == ORC_PAIR_B_OFFS) ? pair_b_q : 8'h00;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pair_a_q <= ORC_PAIR_A_RST;
            pair_b_q <= ORC_PAIR_B_RST;
            rdata_q <= 8'h00;
        end else begin
            if (wr_a) pair_a_q <= cpu_wdata;
            if (wr_b) pair_b_q <= cpu_wdata;
            if (cpu_rd) rdata_q <= rd_mux;
        end
    end
    assign cpu_rdata = rdata_q;

    // pin synchronisers: {prog two, prog one, secondary pll, main pll}
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [1:0] pll_last_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            pll_last_q <= 2'h0;
        end else begin
            sync1_q <= {programmable_rate_two, programmable_rate_one,
                        secondary_analog_pll, main_analog_pll};
            sync2_q <= sync1_q;
            pll_last_q <= sync2_q[1:0];
        end
    end
    wire logic main_rise = sync2_q[0] && !pll_last_q[0];
    wire logic sec_rise = sync2_q[1] && !pll_last_q[1];

    // secondary pll at 62.5MHz locked to its digital pll
    wire logic sec_25m = (secondary_pll_rate_field == ORC_SEC_RATE_62M5)
                         && !secondary_apll_lock_source;

    // fixed 2kHz and 8kHz rates from the core clock
    logic [16:0] cnt_2k_q;
    logic [16:0] cnt_8k_q;
    logic tog_2k_q;
    logic tog_8k_q;
    wire logic end_2k = (cnt_2k_q == 17'(half_2k_cyc - 1));
    wire logic end_8k = (cnt_8k_q == 17'(half_8k_cyc - 1));
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_2k_q <= 17'h0;
            cnt_8k_q <= 17'h0;
            tog_2k_q <= 1'b0;
            tog_8k_q <= 1'b0;
        end else begin
            cnt_2k_q <= end_2k ? 17'h0 : cnt_2k_q + 17'h1;
            cnt_8k_q <= end_8k ? 17'h0 : cnt_8k_q + 17'h1;
            if (end_2k) tog_2k_q <= !tog_2k_q;
            if (end_8k) tog_8k_q <= !tog_8k_q;
        end
    end

    // per-output dividers and source selection
    wire logic [15:0] sels = {pair_b_q, pair_a_q};
    wire logic [3:0] out_w;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_out
            wire logic [3:0] sel = sels[gi*4 +: 4];
            wire orc_route_t route = orc_decode(sel, sec_25m);
            logic [3:0] sel_last_q;
            logic [5:0] div_half_q;
            logic [5:0] div_cnt_q;
            logic div_tog_q;
            logic out_d;
            logic out_q;
            wire logic changed = (sel != sel_last_q) || (route.half != div_half_q);
            wire logic pll_src = (route.src == ORC_SRC_MAIN) || (route.src == ORC_SRC_SEC);
            wire logic pll_rise = (route.src == ORC_SRC_MAIN) ? main_rise : sec_rise;
            wire logic div_end = (div_cnt_q == route.half - 6'd1);
            // old divider phase must not leak out in the cycle of a change
            wire logic div_out = div_tog_q && !changed;

            always_ff @(posedge core_clk) begin
                if (reset) begin
                    sel_last_q <= 4'h0;
                    div_half_q <= 6'h0;
                    div_cnt_q <= 6'h0;
                    div_tog_q <= 1'b0;
                end else begin
                    sel_last_q <= sel;
                    div_half_q <= route.half;
                    if (changed) begin
                        div_cnt_q <= 6'h0;
                        div_tog_q <= 1'b0;
                    end else if (pll_rise && pll_src) begin
                        div_cnt_q <= div_end ? 6'h0 : div_cnt_q + 6'h1;
                        if (div_end) div_tog_q <= !div_tog_q;
                    end
                end
            end

            always_comb begin
                case (route.src)
                    ORC_SRC_OFF: out_d = 1'b0;
                    ORC_SRC_2K: out_d = tog_2k_q;
                    ORC_SRC_8K: out_d = tog_8k_q;
                    ORC_SRC_PROG_TWO: out_d = sync2_q[3];
                    ORC_SRC_PROG_ONE: out_d = sync2_q[2];
                    ORC_SRC_MAIN: out_d = div_out;
                    ORC_SRC_SEC: out_d = div_out;
                    default: out_d = 1'b0;
                endcase
            end

            always_ff @(posedge core_clk) begin
                if (reset) out_q <= 1'b0;
                else out_q <= out_d;
            end
            assign out_w[gi] = out_q;
        end
    endgenerate

    assign clock_output_one = out_w[0];
    assign clock_output_two = out_w[1];
    assign clock_output_three = out_w[2];
    assign clock_output_four = out_w[3];

endmodule // orc_output_clock_rate_select
`default_nettype wire

// File: verification/orc_rate_sel_asserts.sv
// assertions for the output clock rate select block
`default_nettype none
module orc_rate_sel_asserts
    import orc_pkg::*;
#(
    parameter int half_2k_cyc = ORC_HALF_2K_CYC,
    parameter int half_8k_cyc = ORC_HALF_8K_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic main_analog_pll,
    input wire logic secondary_analog_pll,
    input wire logic programmable_rate_one,
    input wire logic programmable_rate_two,
    input wire logic [3:0] secondary_pll_rate_field,
    input wire logic secondary_apll_lock_source,
    input wire logic clock_output_one,
    input wire logic clock_output_two,
    input wire logic clock_output_three,
    input wire logic clock_output_four
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sha_q;
    logic [7:0] shb_q;
    wire logic hit_a = cpu_addr == ORC_PAIR_A_OFFS;
    wire logic hit_b = cpu_addr == ORC_PAIR_B_OFFS;

    // shadow copies of the two selector registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sha_q <= ORC_PAIR_A_RST;
            shb_q <= ORC_PAIR_B_RST;
        end else if (cpu_wr) begin
            sha_q <= hit_a ? cpu_wdata : sha_q;
            shb_q <= hit_b ? cpu_wdata : shb_q;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_pll_sel_new;
        (sha_q[3:0] != $past(sha_q[3:0])) && (sha_q[3:0] >= ORC_SEL_MAIN_48);
    endsequence

    a_one_off_low: assert property ((sha_q[3:0] == ORC_SEL_OFF) [*2] |-> !clock_output_one)
        else $error("output one not low while off");
    a_two_off_low: assert property ((sha_q[7:4] == ORC_SEL_OFF) [*2] |-> !clock_output_two)
        else $error("output two not low while off");
    a_three_off_low: assert property ((shb_q[3:0] == ORC_SEL_OFF) [*2] |-> !clock_output_three)
        else $error("output three not low while off");
    a_four_off_low: assert property ((shb_q[7:4] == ORC_SEL_OFF) [*2] |-> !clock_output_four)
        else $error("output four not low while off");
    a_prog_one_route: assert property (
        (sha_q[3:0] == ORC_SEL_PROG_ONE) [*5]
        |-> clock_output_one == $past(programmable_rate_one, 3))
        else $error("output one not following first programmable rate");
    a_prog_two_route: assert property (
        (sha_q[7:4] == ORC_SEL_PROG_TWO) [*5]
        |-> clock_output_two == $past(programmable_rate_two, 3))
        else $error("output two not following second programmable rate");
    a_restart_low: assert property (s_pll_sel_new |-> ##1 (!clock_output_one) [*4])
        else $error("divider did not restart low on new selector");
    a_read_pair_a: assert property (cpu_rd && hit_a |=> cpu_rdata == $past(sha_q))
        else $error("read of first pair register wrong");
    a_read_pair_b: assert property (cpu_rd && hit_b |=> cpu_rdata == $past(shb_q))
        else $error("read of second pair register wrong");
    a_read_unmapped: assert property (cpu_rd && !hit_a && !hit_b |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!cpu_rd |=> $stable(cpu_rdata))
        else $error("read data changed without a read");
endmodule // orc_rate_sel_asserts

bind orc_output_clock_rate_select orc_rate_sel_asserts #(
    .half_2k_cyc(half_2k_cyc), .half_8k_cyc(half_8k_cyc)
) orc_rate_sel_asserts_inst (
    .core_clk(core_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .main_analog_pll(main_analog_pll), .secondary_analog_pll(secondary_analog_pll),
    .programmable_rate_one(programmable_rate_one),
    .programmable_rate_two(programmable_rate_two),
    .secondary_pll_rate_field(secondary_pll_rate_field),
    .secondary_apll_lock_source(secondary_apll_lock_source),
    .clock_output_one(clock_output_one), .clock_output_two(clock_output_two),
    .clock_output_three(clock_output_three), .clock_output_four(clock_output_four)
);
`default_nettype wire

// File: verification/orc_output_clock_rate_select_tb.sv
// self-checking bench for the output clock rate select block
`default_nettype none
module orc_output_clock_rate_select_tb
    import orc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H2K = 20;
    localparam int H8K = 5;
    localparam int MP = 8;
    localparam int SP = 12;
    localparam int P1 = 16;
    localparam int P2 = 20;
    logic core_clk;
    logic reset;
    logic [7:0] cpu_addr;
    logic [7:0] cpu_wdata;
    logic cpu_wr;
    logic cpu_rd;
    logic [7:0] cpu_rdata;
    logic main_analog_pll;
    logic secondary_analog_pll;
    logic programmable_rate_one;
    logic programmable_rate_two;
    logic [3:0] secondary_pll_rate_field;
    logic secondary_apll_lock_source;
    wire logic [3:0] outs;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] p;
    logic [7:0] d;
    int exp_per [16] = '{0, 2 * H2K, 2 * H8K, P2, P1, 48 * MP, 16 * MP, 12 * MP, 8 * MP,
        6 * MP, 4 * MP, 64 * SP, 48 * SP, 16 * SP, 8 * SP, 4 * SP};

    orc_output_clock_rate_select #(.half_2k_cyc(H2K), .half_8k_cyc(H8K))
    orc_output_clock_rate_select_inst (
        .core_clk(core_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .main_analog_pll(main_analog_pll), .secondary_analog_pll(secondary_analog_pll),
        .programmable_rate_one(programmable_rate_one),
        .programmable_rate_two(programmable_rate_two),
        .secondary_pll_rate_field(secondary_pll_rate_field),
        .secondary_apll_lock_source(secondary_apll_lock_source),
        .clock_output_one(outs[0]), .clock_output_two(outs[1]),
        .clock_output_three(outs[2]), .clock_output_four(outs[3])
    );

    always #2 core_clk = ~core_clk;

    // source clocks with distinct periods in core cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        main_analog_pll <= (cyc % MP) < MP / 2;
        secondary_analog_pll <= (cyc % SP) < SP / 2;
        programmable_rate_one <= (cyc % P1) < P1 / 2;
        programmable_rate_two <= (cyc % P2) < P2 / 2;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        cpu_addr <= a;
        cpu_wdata <= v;
        cpu_wr <= 1'b1;
        @(posedge core_clk);
        cpu_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge core_clk);
        cpu_rd <= 1'b0;
        @(negedge core_clk);
        v = cpu_rdata;
    endtask

    // cycles between two rising edges of one output
    task automatic period(input int i, output logic [15:0] q);
        int n;
        n = 0;
        q = 16'h0000;
        repeat (2) @(negedge core_clk);
        while (outs[i] !== 1'b0 && n < 3000) begin @(negedge core_clk); n++; end
        while (outs[i] !== 1'b1 && n < 3000) begin @(negedge core_clk); n++; end
        while (outs[i] === 1'b1 && n < 3000) begin @(negedge core_clk); n++; q++; end
        while (outs[i] === 1'b0 && n < 3000) begin @(negedge core_clk); n++; q++; end
        if (n >= 3000) begin
            err_count++;
            wrap_up();
        end
    endtask

    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        cpu_addr = 8'h00;
        cpu_wdata = 8'h00;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        secondary_pll_rate_field = 4'h0;
        secondary_apll_lock_source = 1'b0;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(ORC_PAIR_A_OFFS, d);
        chk({8'h00, d}, {8'h00, ORC_PAIR_A_RST});
        rd(ORC_PAIR_B_OFFS, d);
        chk({8'h00, d}, {8'h00, ORC_PAIR_B_RST});
        wr(8'h62, 8'h33);
        rd(8'h62, d);
        chk({8'h00, d}, 16'h0000);
        for (int c = 1; c < 16; c++) begin
            wr(ORC_PAIR_A_OFFS, {ORC_SEL_OFF, 4'(c)});
            period(0, p);
            chk(p, 16'(exp_per[c]));
            chk({15'h0000, outs[1]}, 16'h0000);
        end
        wr(ORC_PAIR_A_OFFS, 8'hA5);
        rd(ORC_PAIR_A_OFFS, d);
        chk({8'h00, d}, 16'h00A5);
        period(1, p);
        chk(p, 16'(4 * MP));
        period(0, p);
        chk(p, 16'(48 * MP));
        wr(ORC_PAIR_B_OFFS, 8'hFB);
        period(3, p);
        chk(p, 16'(4 * SP));
        period(2, p);
        chk(p, 16'(64 * SP));
        @(posedge core_clk);
        secondary_pll_rate_field <= ORC_SEC_RATE_62M5;
        wr(ORC_PAIR_B_OFFS, 8'h0C);
        period(2, p);
        chk(p, 16'(10 * SP));
        chk({15'h0000, outs[3]}, 16'h0000);
        @(posedge core_clk);
        secondary_apll_lock_source <= 1'b1;
        period(2, p);
        chk(p, 16'(48 * SP));
        wr(ORC_PAIR_A_OFFS, 8'h34);
        period(1, p);
        chk(p, 16'(P2));
        period(0, p);
        chk(p, 16'(P1));
        wr(ORC_PAIR_A_OFFS, 8'h00);
        wr(ORC_PAIR_B_OFFS, 8'h00);
        repeat (2) @(negedge core_clk);
        for (int k = 0; k < 40; k++) begin
            @(negedge core_clk);
            chk({12'h000, outs}, 16'h0000);
        end
        wrap_up();
    end
endmodule // orc_output_clock_rate_select_tb
`default_nettype wire
